// ---- rtl/opmap_pkg.sv ----
// Constants, field layouts and carrier types shared by the opcode map decoder.
package opmap_pkg;

  // ******************************************************************
  // Bus and register map
  // ******************************************************************
  localparam int         DW           = 32;
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] REG_INSTR    = 8'h00;
  localparam logic [7:0] REG_RESULT   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_CLEAR    = 8'h0c;
  localparam logic [7:0] REG_ENABLE   = 8'h10;
  localparam logic       HRESP_OKAY   = 1'b0;
  localparam int         HTRANS_ACT   = 1;
  localparam int         NUM_EV       = 4;
  localparam int         EV_ILLEGAL   = 0;
  localparam int         EV_FP_UNIMPL = 1;
  localparam int         EV_SW_RESET  = 2;
  localparam int         EV_DECODED   = 3;
  localparam int         RES_CLS_LO   = 0;
  localparam int         RES_SHIFT64  = 8;
  localparam int         RES_ILLEGAL  = 9;
  localparam int         RES_FP       = 10;
  localparam int         RES_FTT_LO   = 12;
  localparam int         RES_SUB_LO   = 16;

  // ******************************************************************
  // Instruction fields and opcode values
  // ******************************************************************
  localparam int         IMM_BIT = 13;
  localparam int         X_BIT   = 12;
  localparam int         OPF_HI  = 13;
  localparam int         OPF_LO  = 5;
  localparam logic [1:0] FMT_BRANCH = 2'h0, FMT_CALL = 2'h1, FMT_ARITH = 2'h2, FMT_MEM = 2'h3;
  localparam logic [2:0] GRP_ILLEGAL_TRAP_OP = 3'h0, GRP_PINT = 3'h1, GRP_LINT = 3'h2, GRP_RTEST = 3'h3;
  localparam logic [2:0] GRP_SET_HIGH_BITS = 3'h4, GRP_PFLT = 3'h5, GRP_LFLT = 3'h6, GRP_RSVD = 3'h7;
  localparam logic [5:0] OP3_SHL = 6'h25, OP3_SHR = 6'h26, OP3_SRA = 6'h27, OP3_RD_ANC = 6'h28;
  localparam logic [5:0] OP3_POPULATION_COUNT = 6'h2e, OP3_WR_ANC = 6'h30, OP3_WINDOW = 6'h31;
  localparam logic [5:0] OP3_FP1 = 6'h34, OP3_FP2 = 6'h35, OP3_IMP1 = 6'h36, OP3_IMP2 = 6'h37;
  localparam logic [5:0] OP3_TRAP_RET = 6'h3e;
  localparam logic [5:0] OP3_QLD = 6'h22, OP3_QST = 6'h26, OP3_QLDA = 6'h32, OP3_QSTA = 6'h36;
  localparam logic [4:0] ANC_MUL = 5'h00, ANC_CC = 5'h02, ANC_ASI = 5'h03, ANC_TICK = 5'h04;
  localparam logic [4:0] ANC_PC = 5'h05, ANC_FPRS = 5'h06, ANC_AUX_LO = 5'h07, ANC_AUX_HI = 5'h0e;
  localparam logic [4:0] ANC_SPECIAL = 5'h0f, FCN_FIRST = 5'h00, FCN_SECOND = 5'h01;
  localparam logic [63:0] ARITH_RSVD = 64'h8008_0200_2200_0000;
  localparam logic [63:0] MEM_RSVD   = 64'h8f22_df00_1000_1000;
  // Trap type code for a missing float operation; the value is arbitrary.
  localparam logic [2:0]  FTT_UNIMPL = 3'h3;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [5:0] {
    ILLEGAL_TRAP_OP, PREDICTED_INT_BRANCH, LEGACY_INT_BRANCH, REGISTER_TEST_BRANCH, SET_HIGH_BITS,
    PREDICTED_FLOAT_BRANCH, LEGACY_FLOAT_BRANCH, RESERVED_OP, CALL_OP, ARITH_OP,
    WRITE_MULTIPLY_AUX, WRITE_COND_CODES, WRITE_SPACE_ID, WRITE_FLOAT_STATE, WRITE_AUX_STATE,
    SOFTWARE_RESET_REQUEST, READ_MULTIPLY_AUX, READ_COND_CODES, READ_SPACE_ID, READ_CYCLE_COUNTER,
    READ_PROGRAM_COUNTER, READ_FLOAT_STATE, READ_AUX_STATE, MEMORY_BARRIER, STORE_BARRIER,
    WINDOW_A, WINDOW_B, RETURN_TO_NEXT, REISSUE, SHIFT_LEFT_32, SHIFT_LEFT_64,
    SHIFT_RIGHT_LOGICAL_32, SHIFT_RIGHT_LOGICAL_64, SHIFT_RIGHT_ARITH_32, SHIFT_RIGHT_ARITH_64,
    POPULATION_COUNT, FLOAT_ARITH_GROUP, FLOAT_COMPARE_MOVE_GROUP, IMPL_EXTENSION_GROUP_ONE,
    IMPL_EXTENSION_GROUP_TWO, LOAD_STORE_OP, QUAD_FLOAT_LOAD, QUAD_FLOAT_LOAD_ALT,
    QUAD_FLOAT_STORE, QUAD_FLOAT_STORE_ALT
  } cls_t;

  typedef struct packed {
    logic [1:0]  major;
    logic [4:0]  rd;
    logic [5:0]  op3;
    logic [4:0]  rs1;
    logic [13:0] lo;
  } insn_t;

  typedef struct packed {
    cls_t       cls;
    logic [4:0] sub;
    logic       shift64;
    logic       illegal;
    logic       fp_unimpl;
    logic [2:0] ftt;
  } decoded_t;

  typedef struct packed {
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] enable;
    logic              irq;
  } ev_state_t;

  // The ready flag sits in the lowest bit so the reset value can be formed from a plain one.
  typedef struct packed {
    logic              wr_pend;
    logic              rd_wait;
    logic [ADDR_W-1:0] addr;
    insn_t             instr;
    logic              fresh;
    decoded_t          dec;
    logic [DW-1:0]     rdata;
    logic              ready;
  } bus_state_t;

  localparam bus_state_t BUS_RESET = bus_state_t'({{($bits(bus_state_t) - 1){1'b0}}, 1'b1});

endpackage : opmap_pkg

// ---- rtl/float_opf_check.sv ----
// Lookup of the implemented sub-opcodes of both floating-point operation groups.
`timescale 1ns/1ps
module float_opf_check (
  input  wire logic [8:0] opf,
  output logic            fp1_ok,
  output logic            fp2_ok
);
  import opmap_pkg::*;

  logic [7:0]  fp1_cols;
  logic [15:0] fp2_cols;

  // ******************************************************************
  // Column masks per row; everything not listed is reserved or shaded
  // ******************************************************************
  always_comb
  begin
    fp1_cols = 8'h00;
    fp2_cols = 16'h0000;
    case (opf[8:3])
      6'h00, 6'h08, 6'h09: fp1_cols = 8'hee;
      6'h01, 6'h05, 6'h1a: fp1_cols = 8'h0e;
      6'h0d: fp1_cols = 8'h42;
      6'h10: fp1_cols = 8'h1e;
      6'h11: fp1_cols = 8'h11;
      6'h18: fp1_cols = 8'hd0;
      6'h19: fp1_cols = 8'h7b;
      default: fp1_cols = 8'h00;
    endcase
    case (opf[8:4])
      5'h00, 5'h08, 5'h10, 5'h18: fp2_cols = 16'h000e;
      5'h02, 5'h06, 5'h0a, 5'h0e: fp2_cols = 16'h00e0;
      5'h04, 5'h05, 5'h0c: fp2_cols = 16'h00ee;
      default: fp2_cols = 16'h0000;
    endcase
    fp1_ok = fp1_cols[opf[2:0]];
    fp2_ok = fp2_cols[opf[3:0]];
  end

endmodule : float_opf_check

// ---- rtl/event_status.sv ----
// Sticky event flags, their enable mask and the level interrupt.
`timescale 1ns/1ps
module event_status (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic [opmap_pkg::NUM_EV-1:0] ev_set,
  input  wire logic                        clr_wr,
  input  wire logic                        en_wr,
  input  wire logic [opmap_pkg::NUM_EV-1:0] wdata,
  output logic [opmap_pkg::NUM_EV-1:0]      status,
  output logic [opmap_pkg::NUM_EV-1:0]      enable,
  output logic                             irq
);
  import opmap_pkg::*;

  ev_state_t         s_reg;
  ev_state_t         s_next;
  logic [NUM_EV-1:0] st_next;

  // A new event in the clearing cycle survives the clear.
  for (genvar i = 0; i < NUM_EV; i++)
  begin : g_flag
    assign st_next[i] = ev_set[i] | (s_reg.status[i] & ~(clr_wr & wdata[i]));
  end

  always_comb
  begin
    s_next        = s_reg;
    s_next.status = st_next;
    s_next.enable = en_wr ? wdata : s_reg.enable;
    s_next.irq    = |(st_next & s_next.enable);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign status = s_reg.status;
  assign enable = s_reg.enable;
  assign irq    = s_reg.irq;

endmodule : event_status

// ---- rtl/opcode_map_decoder.sv ----
// Instruction opcode classifier with an AHB-Lite register window and event interrupt.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module opcode_map_decoder (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output opmap_pkg::cls_t  decoded_class,
  output logic             trap_illegal,
  output logic             trap_float,
  output logic             irq
);
  import opmap_pkg::*;

  bus_state_t        s_reg;
  bus_state_t        s_next;
  decoded_t          dec_c;
  logic              fp1_ok;
  logic              fp2_ok;
  logic              accept;
  logic              clr_wr;
  logic              en_wr;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] enable;
  logic [DW-1:0]     result_word;
  logic [DW-1:0]     read_word;

  // ******************************************************************
  // Decode functions
  // ******************************************************************
  function automatic decoded_t decode_arith(insn_t w, logic f1, logic f2);
    decoded_t d;
    logic     rsv;
    d     = '0;
    rsv   = 1'b0;
    d.cls = ARITH_OP;
    d.sub = w.rd;
    if (ARITH_RSVD[w.op3])
      rsv = 1'b1;
    else
    begin
      case (w.op3)
        OP3_WR_ANC:
        begin
          if (w.rd == ANC_MUL) d.cls = WRITE_MULTIPLY_AUX;
          else if (w.rd == ANC_CC) d.cls = WRITE_COND_CODES;
          else if (w.rd == ANC_ASI) d.cls = WRITE_SPACE_ID;
          else if (w.rd == ANC_FPRS) d.cls = WRITE_FLOAT_STATE;
          else if (w.rd >= ANC_AUX_LO && w.rd <= ANC_AUX_HI) d.cls = WRITE_AUX_STATE;
          else if (w.rd == ANC_SPECIAL && w.rs1 == ANC_MUL && w.lo[IMM_BIT])
            d.cls = SOFTWARE_RESET_REQUEST;
          else rsv = 1'b1;
        end
        OP3_RD_ANC:
        begin
          d.sub = w.rs1;
          if (w.rs1 == ANC_MUL) d.cls = READ_MULTIPLY_AUX;
          else if (w.rs1 == ANC_CC) d.cls = READ_COND_CODES;
          else if (w.rs1 == ANC_ASI) d.cls = READ_SPACE_ID;
          else if (w.rs1 == ANC_TICK) d.cls = READ_CYCLE_COUNTER;
          else if (w.rs1 == ANC_PC) d.cls = READ_PROGRAM_COUNTER;
          else if (w.rs1 == ANC_FPRS) d.cls = READ_FLOAT_STATE;
          else if (w.rs1 >= ANC_AUX_LO && w.rs1 <= ANC_AUX_HI) d.cls = READ_AUX_STATE;
          else if (w.rs1 == ANC_SPECIAL && w.rd == ANC_MUL)
            d.cls = w.lo[IMM_BIT] ? MEMORY_BARRIER : STORE_BARRIER;
          else rsv = 1'b1;
        end
        OP3_WINDOW:
        begin
          if (w.rd == FCN_FIRST) d.cls = WINDOW_A;
          else if (w.rd == FCN_SECOND) d.cls = WINDOW_B;
          else rsv = 1'b1;
        end
        OP3_TRAP_RET:
        begin
          if (w.rd == FCN_FIRST) d.cls = RETURN_TO_NEXT;
          else if (w.rd == FCN_SECOND) d.cls = REISSUE;
          else rsv = 1'b1;
        end
        OP3_SHL:
        begin
          d.shift64 = w.lo[X_BIT];
          d.cls     = w.lo[X_BIT] ? SHIFT_LEFT_64 : SHIFT_LEFT_32;
        end
        OP3_SHR:
        begin
          d.shift64 = w.lo[X_BIT];
          d.cls     = w.lo[X_BIT] ? SHIFT_RIGHT_LOGICAL_64 : SHIFT_RIGHT_LOGICAL_32;
        end
        OP3_SRA:
        begin
          d.shift64 = w.lo[X_BIT];
          d.cls     = w.lo[X_BIT] ? SHIFT_RIGHT_ARITH_64 : SHIFT_RIGHT_ARITH_32;
        end
        OP3_POPULATION_COUNT:
        begin
          d.sub = w.rs1;
          if (w.rs1 == ANC_MUL)
          begin
            d.cls     = POPULATION_COUNT;
            d.illegal = 1'b1;
          end
          else
            rsv = 1'b1;
        end
        OP3_FP1:
        begin
          d.cls       = FLOAT_ARITH_GROUP;
          d.fp_unimpl = ~f1;
        end
        OP3_FP2:
        begin
          d.cls       = FLOAT_COMPARE_MOVE_GROUP;
          d.fp_unimpl = ~f2;
        end
        OP3_IMP1: d.cls = IMPL_EXTENSION_GROUP_ONE;
        OP3_IMP2: d.cls = IMPL_EXTENSION_GROUP_TWO;
        default: d.cls = ARITH_OP;
      endcase
    end
    if (rsv)
    begin
      d.cls     = RESERVED_OP;
      d.illegal = 1'b1;
    end
    d.ftt = d.fp_unimpl ? FTT_UNIMPL : 3'h0;
    return d;
  endfunction : decode_arith

  function automatic decoded_t decode_word(insn_t w, logic f1, logic f2);
    decoded_t d;
    d     = '0;
    d.sub = w.rd;
    case (w.major)
      FMT_BRANCH:
      begin
        case (w.op3[5:3])
          GRP_ILLEGAL_TRAP_OP: d.cls = ILLEGAL_TRAP_OP;
          GRP_PINT: d.cls = PREDICTED_INT_BRANCH;
          GRP_LINT: d.cls = LEGACY_INT_BRANCH;
          GRP_RTEST: d.cls = REGISTER_TEST_BRANCH;
          GRP_SET_HIGH_BITS: d.cls = SET_HIGH_BITS;
          GRP_PFLT: d.cls = PREDICTED_FLOAT_BRANCH;
          GRP_LFLT: d.cls = LEGACY_FLOAT_BRANCH;
          default: d.cls = RESERVED_OP;
        endcase
        d.illegal = (w.op3[5:3] == GRP_ILLEGAL_TRAP_OP) || (w.op3[5:3] == GRP_RSVD);
      end
      FMT_CALL: d.cls = CALL_OP;
      FMT_ARITH: d = decode_arith(w, f1, f2);
      default:
      begin
        d.illegal = 1'b1;
        if (w.op3 == OP3_QLD) d.cls = QUAD_FLOAT_LOAD;
        else if (w.op3 == OP3_QLDA) d.cls = QUAD_FLOAT_LOAD_ALT;
        else if (w.op3 == OP3_QST) d.cls = QUAD_FLOAT_STORE;
        else if (w.op3 == OP3_QSTA) d.cls = QUAD_FLOAT_STORE_ALT;
        else if (MEM_RSVD[w.op3]) d.cls = RESERVED_OP;
        else
        begin
          d.cls     = LOAD_STORE_OP;
          d.illegal = 1'b0;
        end
      end
    endcase
    return d;
  endfunction : decode_word

  // ******************************************************************
  // Decoder core
  // ******************************************************************
  float_opf_check u_fp (
    .opf    (s_reg.instr.lo[OPF_HI:OPF_LO]),
    .fp1_ok (fp1_ok),
    .fp2_ok (fp2_ok)
  );

  // The classifier is pure logic; only the pipeline copy below is clocked.
  assign dec_c = decode_word(s_reg.instr, fp1_ok, fp2_ok);

  always_comb
  begin
    result_word = '0;
    result_word[RES_CLS_LO +: $bits(cls_t)] = dec_c.cls;
    result_word[RES_SHIFT64]                = dec_c.shift64;
    result_word[RES_ILLEGAL]                = dec_c.illegal;
    result_word[RES_FP]                     = dec_c.fp_unimpl;
    result_word[RES_FTT_LO +: 3]            = dec_c.ftt;
    result_word[RES_SUB_LO +: 5]            = dec_c.sub;
  end

  // ******************************************************************
  // Register window and bus slave
  // ******************************************************************
  assign accept = hsel & hready & htrans[HTRANS_ACT];
  assign clr_wr = s_reg.wr_pend && (s_reg.addr == REG_CLEAR);
  assign en_wr  = s_reg.wr_pend && (s_reg.addr == REG_ENABLE);

  always_comb
  begin
    read_word = '0;
    if (s_reg.addr == REG_INSTR)
      read_word = s_reg.instr;
    else if (s_reg.addr == REG_RESULT)
      read_word = result_word;
    else if (s_reg.addr == REG_STATUS)
      read_word[NUM_EV-1:0] = status;
    else if (s_reg.addr == REG_ENABLE)
      read_word[NUM_EV-1:0] = enable;
    else
      read_word = '0;
  end

  // Reads take one wait state so a read just after a write sees the new word decoded.
  always_comb
  begin
    s_next         = s_reg;
    s_next.fresh   = 1'b0;
    s_next.ready   = 1'b1;
    s_next.dec     = dec_c;
    s_next.wr_pend = accept & hwrite;
    if (s_reg.wr_pend && s_reg.addr == REG_INSTR)
    begin
      s_next.instr = hwdata;
      s_next.fresh = 1'b1;
    end
    if (s_reg.rd_wait)
    begin
      s_next.rd_wait = 1'b0;
      s_next.rdata   = read_word;
    end
    if (accept)
    begin
      s_next.addr = haddr[ADDR_W-1:0];
      if (!hwrite)
      begin
        s_next.rd_wait = 1'b1;
        s_next.ready   = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= BUS_RESET;
    else
      s_reg <= s_next;
  end

  // ******************************************************************
  // Events and interrupt
  // ******************************************************************
  assign ev_set[EV_ILLEGAL]   = s_reg.fresh & dec_c.illegal;
  assign ev_set[EV_FP_UNIMPL] = s_reg.fresh & dec_c.fp_unimpl;
  assign ev_set[EV_SW_RESET]  = s_reg.fresh & (dec_c.cls == SOFTWARE_RESET_REQUEST);
  assign ev_set[EV_DECODED]   = s_reg.fresh;

  event_status u_ev (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ev_set  (ev_set),
    .clr_wr  (clr_wr),
    .en_wr   (en_wr),
    .wdata   (hwdata[NUM_EV-1:0]),
    .status  (status),
    .enable  (enable),
    .irq     (irq)
  );

  assign hreadyout     = s_reg.ready;
  assign hresp         = HRESP_OKAY;
  assign hrdata        = s_reg.rdata;
  assign decoded_class = s_reg.dec.cls;
  assign trap_illegal  = s_reg.dec.illegal;
  assign trap_float    = s_reg.dec.fp_unimpl;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic is_arith;
  logic is_branch;
  assign is_arith  = s_reg.instr.major == FMT_ARITH;
  assign is_branch = s_reg.instr.major == FMT_BRANCH;

  a_call_format: assert property ((s_reg.instr.major == FMT_CALL) |=> decoded_class == CALL_OP)
    else $error("call format not classified as call");
  a_branch_group: assert property ((is_branch && s_reg.instr.op3[5:3] == GRP_PINT)
    |=> decoded_class == PREDICTED_INT_BRANCH)
    else $error("predicted integer branch misclassified");
  a_branch_trap: assert property ((is_branch && (s_reg.instr.op3[5:3] == GRP_ILLEGAL_TRAP_OP
    || s_reg.instr.op3[5:3] == GRP_RSVD)) |=> trap_illegal)
    else $error("illegal or reserved branch group did not trap");
  a_arith_reserved: assert property ((is_arith && ARITH_RSVD[s_reg.instr.op3])
    |=> trap_illegal && decoded_class == RESERVED_OP)
    else $error("reserved arithmetic opcode did not trap");
  a_shaded_float: assert property ((is_arith && s_reg.instr.op3 == OP3_FP1 && !fp1_ok)
    |=> trap_float && !trap_illegal && s_reg.dec.ftt == FTT_UNIMPL)
    else $error("shaded float opcode not flagged unimplemented");
  a_float_two: assert property ((is_arith && s_reg.instr.op3 == OP3_FP2)
    |=> trap_float == !$past(fp2_ok))
    else $error("second float group trap wrong");
  a_write_target: assert property ((is_arith && s_reg.instr.op3 == OP3_WR_ANC
    && s_reg.instr.rd == ANC_CC) |=> decoded_class == WRITE_COND_CODES)
    else $error("condition code write target wrong");
  a_barrier_kind: assert property ((is_arith && s_reg.instr.op3 == OP3_RD_ANC
    && s_reg.instr.rs1 == ANC_SPECIAL && s_reg.instr.rd == ANC_MUL)
    |=> decoded_class == ($past(s_reg.instr.lo[IMM_BIT]) ? MEMORY_BARRIER : STORE_BARRIER))
    else $error("barrier kind wrong");
  a_window_pair: assert property ((is_arith && s_reg.instr.op3 == OP3_WINDOW
    && s_reg.instr.rd == FCN_SECOND) |=> decoded_class == WINDOW_B)
    else $error("second window function misclassified");
  a_shift_width: assert property ((is_arith && s_reg.instr.op3 == OP3_SRA)
    |=> s_reg.dec.shift64 == $past(s_reg.instr.lo[X_BIT]))
    else $error("shift width does not follow extended bit");
  a_population_count_trap: assert property ((is_arith && s_reg.instr.op3 == OP3_POPULATION_COUNT) |=> trap_illegal)
    else $error("population count did not trap");
  a_quad_trap: assert property ((s_reg.instr.major == FMT_MEM && s_reg.instr.op3 == OP3_QSTA)
    |=> trap_illegal && decoded_class == QUAD_FLOAT_STORE_ALT)
    else $error("quad float store did not trap");
  a_ext_route: assert property ((is_arith && s_reg.instr.op3 == OP3_IMP2)
    |=> decoded_class == IMPL_EXTENSION_GROUP_TWO && !trap_illegal)
    else $error("extension group misrouted");
  a_one_trap: assert property (!(trap_illegal && trap_float))
    else $error("two trap requests for one word");
  a_read_wait: assert property ((accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");
  a_event_irq: assert property ((s_reg.fresh && dec_c.illegal && enable[EV_ILLEGAL]) |=> irq)
    else $error("enabled illegal event did not raise interrupt");

  c_float_trap: cover property (trap_float ##1 irq);
  c_sw_reset: cover property (decoded_class == SOFTWARE_RESET_REQUEST);
  c_read_back: cover property ((accept && !hwrite) ##2 hreadyout);
  c_irq_clear: cover property (irq ##1 clr_wr ##1 !irq);

endmodule : opcode_map_decoder

// ---- bench/ahb_host_model.sv ----
// Bus master standing in for the fetch side, issuing single word transfers.
`timescale 1ns/1ps
module ahb_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // A read data phase drives the inverse of hwdata, so a slave that samples write data as late as a following read sees a wrong word.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
endmodule : ahb_host_model

// ---- bench/opcode_map_decoder_test.sv ----
// Self-checking bench of the opcode map decoder with a table model of the decode.
`timescale 1ns/1ps
module opcode_map_decoder_test;
  import opmap_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, trap_illegal, trap_float, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  st = 4'h0;
  logic [3:0]  en;
  cls_t        decoded_class;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #20 hclk = ~hclk;

  ahb_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  opcode_map_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .decoded_class(decoded_class), .trap_illegal(trap_illegal),
    .trap_float(trap_float), .irq(irq));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    cmp(q, e);
    cmp({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : rd

  // The model keeps the sticky flags itself: bit 3 on every word, bit 2 for a reset request.
  task automatic chk(input logic [31:0] w, input cls_t c, input logic [1:0] t);
    logic [31:0] q;
    logic        s64;
    s64 = c inside {SHIFT_LEFT_64, SHIFT_RIGHT_LOGICAL_64, SHIFT_RIGHT_ARITH_64};
    host.xfer(1'b1, REG_INSTR, w, q);
    host.xfer(1'b0, REG_RESULT, 32'h0, q);
    st = st | 4'h8 | {1'b0, c == SOFTWARE_RESET_REQUEST, t};
    cmp(q & 32'h0000_773f, {17'h0, (t[1] ? FTT_UNIMPL : 3'h0), 1'b0, t, s64, 2'h0, c});
    cmp({22'h0, trap_float, trap_illegal, 2'h0, decoded_class}, {22'h0, t, 2'h0, c});
    cmp({31'h0, irq}, {31'h0, |(st & en)});
  endtask : chk

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h31b0c1de));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    en = 4'($urandom) | 4'h1;
    host.xfer(1'b1, REG_ENABLE, {28'h0, en}, r);
    rd(REG_ENABLE, {28'h0, en});
    chk(32'h0000_0000, ILLEGAL_TRAP_OP, 2'h1);
    chk(32'h01c0_0000, RESERVED_OP, 2'h1);
    chk(32'h0040_0000, PREDICTED_INT_BRANCH, 2'h0);
    chk(32'h0080_0000, LEGACY_INT_BRANCH, 2'h0);
    chk(32'h00c0_0000, REGISTER_TEST_BRANCH, 2'h0);
    chk(32'h0100_0000, SET_HIGH_BITS, 2'h0);
    chk(32'h0140_0000, PREDICTED_FLOAT_BRANCH, 2'h0);
    chk(32'h0180_0000, LEGACY_FLOAT_BRANCH, 2'h0);
    chk(32'h8580_0000, WRITE_COND_CODES, 2'h0);
    chk(32'h9f80_2000, SOFTWARE_RESET_REQUEST, 2'h0);
    chk(32'h8143_e000, MEMORY_BARRIER, 2'h0);
    chk(32'h8143_c000, STORE_BARRIER, 2'h0);
    chk(32'h8141_4000, READ_PROGRAM_COUNTER, 2'h0);
    chk(32'h8388_0000, WINDOW_B, 2'h0);
    chk(32'h81f0_0000, RETURN_TO_NEXT, 2'h0);
    chk(32'h8128_1000, SHIFT_LEFT_64, 2'h0);
    chk(32'h8138_0000, SHIFT_RIGHT_ARITH_32, 2'h0);
    chk(32'h8170_0000, POPULATION_COUNT, 2'h1);
    chk(32'h80c8_0000, RESERVED_OP, 2'h1);
    chk(32'h81a0_0020, FLOAT_ARITH_GROUP, 2'h0);
    chk(32'h81a0_0000, FLOAT_ARITH_GROUP, 2'h2);
    chk(32'h81a8_00a0, FLOAT_COMPARE_MOVE_GROUP, 2'h2);
    chk(32'h81b8_0000, IMPL_EXTENSION_GROUP_TWO, 2'h0);
    chk(32'hc110_0000, QUAD_FLOAT_LOAD, 2'h1);
    chk(32'hc1b0_0000, QUAD_FLOAT_STORE_ALT, 2'h1);
    chk(32'hc140_0000, RESERVED_OP, 2'h1);
    chk(32'hc190_0000, QUAD_FLOAT_LOAD_ALT, 2'h1);
    chk(32'hc130_0000, QUAD_FLOAT_STORE, 2'h1);
    chk(32'hc060_0000, RESERVED_OP, 2'h1);
    chk(32'hc000_0000, LOAD_STORE_OP, 2'h0);
    chk(32'h8000_0000, ARITH_OP, 2'h0);
    chk(32'h8180_0000, WRITE_MULTIPLY_AUX, 2'h0);
    chk(32'h8380_0000, RESERVED_OP, 2'h1);
    chk(32'h8780_0000, WRITE_SPACE_ID, 2'h0);
    chk(32'h8d80_0000, WRITE_FLOAT_STATE, 2'h0);
    chk(32'h9d80_0000, WRITE_AUX_STATE, 2'h0);
    chk(32'h9f80_0000, RESERVED_OP, 2'h1);
    chk(32'h8140_0000, READ_MULTIPLY_AUX, 2'h0);
    chk(32'h8140_4000, RESERVED_OP, 2'h1);
    chk(32'h8140_8000, READ_COND_CODES, 2'h0);
    chk(32'h8140_c000, READ_SPACE_ID, 2'h0);
    chk(32'h8141_0000, READ_CYCLE_COUNTER, 2'h0);
    chk(32'h8141_8000, READ_FLOAT_STATE, 2'h0);
    chk(32'h8141_c000, READ_AUX_STATE, 2'h0);
    chk(32'h8343_c000, RESERVED_OP, 2'h1);
    chk(32'h8188_0000, WINDOW_A, 2'h0);
    chk(32'h8588_0000, RESERVED_OP, 2'h1);
    chk(32'h83f0_0000, REISSUE, 2'h0);
    chk(32'h8128_0000, SHIFT_LEFT_32, 2'h0);
    chk(32'h8130_0000, SHIFT_RIGHT_LOGICAL_32, 2'h0);
    chk(32'h8130_1000, SHIFT_RIGHT_LOGICAL_64, 2'h0);
    chk(32'h8138_1000, SHIFT_RIGHT_ARITH_64, 2'h0);
    chk(32'h8170_4000, RESERVED_OP, 2'h1);
    chk(32'h81b0_0000, IMPL_EXTENSION_GROUP_ONE, 2'h0);
    chk(32'h81a8_0a20, FLOAT_COMPARE_MOVE_GROUP, 2'h0);
    chk(32'h81a0_1960, FLOAT_ARITH_GROUP, 2'h0);
    repeat (8) chk({2'h1, 30'($urandom)}, CALL_OP, 2'h0);
    rd(REG_STATUS, {28'h0, st});
    host.xfer(1'b1, REG_CLEAR, {28'h0, st}, r);
    rd(REG_STATUS, 32'h0);
    rd(REG_CLEAR, 32'h0);
    rd(8'h40, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule : opcode_map_decoder_test
